// ### design/sbi_pkg.sv
/*
  Shared constants for the burst SRAM pin interface: data and byte lane
  layout, address width, two-entry crossing buffer and mode detection.
  Assumes a device with a 36-bit data port and 9-bit byte lanes.
*/
package sbi_pkg;
  localparam int DATA_W = 36;            // Width of one data transfer
  localparam int LANE_W = 9;             // One byte lane
  localparam int LANES = 4;              // Byte lanes per transfer
  localparam int WORD_W = 2 * DATA_W;    // One two-transfer burst word
  localparam int ADDR_W = 21;            // Burst word address
  localparam int PTR_W = 2;              // Two entries plus wrap bit
  localparam int IDLE_W = 4;             // Width of the idle counter
  localparam logic [IDLE_W-1:0] IDLE_CYC = 4'h8;      // Input clock cycles of still output clock
  localparam logic [PTR_W-1:0] PTR_ONE = 2'h1;
  localparam logic [PTR_W-1:0] PTR_RST = 2'h0;
  localparam logic [PTR_W-1:0] PTR_FULL_X = 2'h3;      // Gray full: both bits differ
  localparam logic [PTR_W-1:0] PTR_DEPTH = 2'h2;       // Entries in the buffer
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
  localparam logic [LANES-1:0] BYTE_OFF = 4'hF;
endpackage

// ### design/sbi_sram_if.sv
/*
  Pin-level logic of a burst SRAM with separate read and write ports.
  Assumes sys_clk_i is the positive input clock with its complement on the
  falling edge, and out_clk_i the output clock pair likewise; both come
  from the memory controller, which keeps to the documented timing.
  Read data is muxed from launch clock flops, since a double-rate pin
  cannot come straight from a single register; echo clocks are the launch clock and its inverse.
  The launch clock switch between modes is not glitch free; change modes
  only with the read port idle.
*/
`timescale 1ns/1ps

module sbi_sram_if #(
  parameter int MEM_AW = sbi_pkg::ADDR_W
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic out_clk_i,
  input wire logic [sbi_pkg::ADDR_W-1:0] addr_i,
  input wire logic write_port_select_n_i,
  input wire logic read_port_select_n_i,
  input wire logic [sbi_pkg::LANES-1:0] byte_write_select_n_i,
  input wire logic [sbi_pkg::DATA_W-1:0] wdata_i,
  output logic [sbi_pkg::DATA_W-1:0] rdata_o,
  output logic rdata_oe_n_o,
  output logic echo_clock_pos_o,
  output logic echo_clock_neg_o
);

  // Array of burst words, low half first transfer, high half second
  logic [sbi_pkg::WORD_W-1:0] mem_r [0:(2**MEM_AW)-1];

  logic wr_arm_r;
  logic wr_go_r;
  logic [sbi_pkg::DATA_W-1:0] wd_lo_r;
  logic [sbi_pkg::DATA_W-1:0] wd_hi_r;
  logic [sbi_pkg::LANES-1:0] wb_lo_r;
  logic [sbi_pkg::LANES-1:0] wb_hi_r;
  logic [sbi_pkg::ADDR_W-1:0] wa_r;
  // Whole burst word after the byte merge
  logic [sbi_pkg::WORD_W-1:0] wr_word;

  logic [sbi_pkg::WORD_W-1:0] fifo_r [0:1];
  logic [sbi_pkg::PTR_W-1:0] wbin_r;
  logic [sbi_pkg::PTR_W-1:0] wgray_r;
  logic [sbi_pkg::PTR_W-1:0] rbin_r;
  logic [sbi_pkg::PTR_W-1:0] rgray_r;
  logic [sbi_pkg::PTR_W-1:0] rg_s1_r;
  logic [sbi_pkg::PTR_W-1:0] rg_s2_r;
  logic [sbi_pkg::PTR_W-1:0] wg_s1_r;
  logic [sbi_pkg::PTR_W-1:0] wg_s2_r;
  logic [sbi_pkg::PTR_W-1:0] wbin_nxt;
  logic [sbi_pkg::PTR_W-1:0] rbin_nxt;
  logic [sbi_pkg::PTR_W-1:0] rg_bin;
  logic fill_ready;
  logic fill_valid;
  logic drain_valid;
  logic drain_ready;

  logic oc_s1_r;
  logic oc_s2_r;
  logic oc_s3_r;
  logic [sbi_pkg::IDLE_W-1:0] idle_cnt_r;
  logic single_mode_r;
  logic launch_clk;

  logic [sbi_pkg::DATA_W-1:0] q_pos_r;
  logic [sbi_pkg::DATA_W-1:0] q_neg_r;
  logic [sbi_pkg::DATA_W-1:0] q_hold_r;
  logic q_oe_n_r;

  // Write select and first half, positive input edge only
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_arm_r <= 1'b0;
      wd_lo_r <= sbi_pkg::DATA_RST;
      wb_lo_r <= sbi_pkg::BYTE_OFF;
    end
    else
    begin
      wr_arm_r <= !write_port_select_n_i;
      if (!write_port_select_n_i)
      begin
        wd_lo_r <= wdata_i;
        wb_lo_r <= byte_write_select_n_i;
      end
    end
  end

  // Second half and write address on the complementary edge
  always_ff @(negedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_go_r <= 1'b0;
      wa_r <= '0;
      wd_hi_r <= sbi_pkg::DATA_RST;
      wb_hi_r <= sbi_pkg::BYTE_OFF;
    end
    else
    begin
      wr_go_r <= wr_arm_r;
      if (wr_arm_r)
      begin
        wa_r <= addr_i;
        wd_hi_r <= wdata_i;
        wb_hi_r <= byte_write_select_n_i;
      end
    end
  end

  // Byte merge, one lane per loop pass; unselected lanes keep the stored
  // bits, so a single process owns the whole array
  for (genvar g = 0; g < sbi_pkg::LANES; g++)
  begin : g_lane
    assign wr_word[g*sbi_pkg::LANE_W +: sbi_pkg::LANE_W] = wb_lo_r[g] ?
      mem_r[wa_r[MEM_AW-1:0]][g*sbi_pkg::LANE_W +: sbi_pkg::LANE_W] :
      wd_lo_r[g*sbi_pkg::LANE_W +: sbi_pkg::LANE_W];
    assign wr_word[sbi_pkg::DATA_W + g*sbi_pkg::LANE_W +: sbi_pkg::LANE_W] = wb_hi_r[g] ?
      mem_r[wa_r[MEM_AW-1:0]][sbi_pkg::DATA_W + g*sbi_pkg::LANE_W +: sbi_pkg::LANE_W] :
      wd_hi_r[g*sbi_pkg::LANE_W +: sbi_pkg::LANE_W];
  end

  // Array update on the positive edge half an input clock after the write address arrives
  always_ff @(posedge sys_clk_i)
  begin
    if (wr_go_r)
      mem_r[wa_r[MEM_AW-1:0]] <= wr_word;
  end

  // Fill side: a read is taken only while the buffer has room
  assign fill_valid = !read_port_select_n_i;
  assign fill_ready = (wgray_r ^ rg_s2_r) != sbi_pkg::PTR_FULL_X;
  assign wbin_nxt = wbin_r + sbi_pkg::PTR_ONE;
  // Synchronised read pointer back in binary, for the overrun check
  assign rg_bin = rg_s2_r ^ (rg_s2_r >> 1);

  // Array read is asynchronous; the address shares this clock, no sync
  always_ff @(posedge sys_clk_i)
  begin
    if (fill_valid && fill_ready)
      fifo_r[wbin_r[0]] <= mem_r[addr_i[MEM_AW-1:0]];
  end

  // Write pointer and the synchronised read pointer
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wbin_r <= sbi_pkg::PTR_RST;
      wgray_r <= sbi_pkg::PTR_RST;
      rg_s1_r <= sbi_pkg::PTR_RST;
      rg_s2_r <= sbi_pkg::PTR_RST;
    end
    else
    begin
      rg_s1_r <= rgray_r;
      rg_s2_r <= rg_s1_r;
      if (fill_valid && fill_ready)
      begin
        wbin_r <= wbin_nxt;
        wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
      end
    end
  end

  // Output clock activity watch; a clock held still means single mode
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      oc_s1_r <= 1'b0;
      oc_s2_r <= 1'b0;
      oc_s3_r <= 1'b0;
      idle_cnt_r <= '0;
      single_mode_r <= 1'b0;
    end
    else
    begin
      oc_s1_r <= out_clk_i;
      oc_s2_r <= oc_s1_r;
      oc_s3_r <= oc_s2_r;
      if (oc_s2_r != oc_s3_r)
        idle_cnt_r <= '0;
      else if (idle_cnt_r != sbi_pkg::IDLE_CYC)
        idle_cnt_r <= idle_cnt_r + 1'b1;
      single_mode_r <= (idle_cnt_r == sbi_pkg::IDLE_CYC);
    end
  end

  // Launch clock; switching is only safe while no read is in flight
  assign launch_clk = single_mode_r ? sys_clk_i : out_clk_i;

  assign drain_valid = rgray_r != wg_s2_r;
  assign drain_ready = 1'b1;
  assign rbin_nxt = rbin_r + sbi_pkg::PTR_ONE;

  // Drain side: read pointer and synchronised write pointer
  always_ff @(posedge launch_clk or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rbin_r <= sbi_pkg::PTR_RST;
      rgray_r <= sbi_pkg::PTR_RST;
      wg_s1_r <= sbi_pkg::PTR_RST;
      wg_s2_r <= sbi_pkg::PTR_RST;
    end
    else
    begin
      wg_s1_r <= wgray_r;
      wg_s2_r <= wg_s1_r;
      if (drain_valid && drain_ready)
      begin
        rbin_r <= rbin_nxt;
        rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
      end
    end
  end

  // First transfer and driver enable on the positive launch edge
  always_ff @(posedge launch_clk or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      q_pos_r <= sbi_pkg::DATA_RST;
      q_hold_r <= sbi_pkg::DATA_RST;
      q_oe_n_r <= 1'b1;
    end
    else if (drain_valid)
    begin
      q_pos_r <= fifo_r[rbin_r[0]][sbi_pkg::DATA_W-1:0];
      q_hold_r <= fifo_r[rbin_r[0]][sbi_pkg::WORD_W-1:sbi_pkg::DATA_W];
      q_oe_n_r <= 1'b0;
    end
    else
      q_oe_n_r <= 1'b1;
  end

  // Second transfer on the complementary launch edge
  always_ff @(negedge launch_clk or negedge reset_n_i)
  begin
    if (!reset_n_i)
      q_neg_r <= sbi_pkg::DATA_RST;
    else
      q_neg_r <= q_hold_r;
  end

  // Double-rate output: each half shown while its own edge owns the pin
  assign rdata_o = launch_clk ? q_pos_r : q_neg_r;
  assign rdata_oe_n_o = q_oe_n_r;
  assign echo_clock_pos_o = launch_clk;
  assign echo_clock_neg_o = !launch_clk;

  // Write path checks
  chk_write_gated: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    wr_go_r |-> !$past(write_port_select_n_i))
    else $error("write performed without write select");
  chk_write_taken: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !write_port_select_n_i |=> wr_go_r)
    else $error("selected write not performed");
  chk_byte_mask: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    wr_go_r |-> wb_lo_r == $past(byte_write_select_n_i))
    else $error("first half byte selects not held");
  chk_write_idle: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    write_port_select_n_i |=> !wr_arm_r)
    else $error("write armed while write port deselected");

  // Write address must stay put while no write is armed
  chk_waddr_ignore: assert property (@(negedge sys_clk_i) disable iff (!reset_n_i)
    !wr_arm_r |=> wa_r == $past(wa_r))
    else $error("write address taken while write port deselected");

  // Read request checks
  chk_read_capture: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (!read_port_select_n_i && fill_ready) |=> wbin_r == $past(wbin_r) + sbi_pkg::PTR_ONE)
    else $error("selected read not taken");
  chk_read_ignore: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    read_port_select_n_i |=> wbin_r == $past(wbin_r))
    else $error("deselected read port took a request");
  chk_read_refused: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (!read_port_select_n_i && !fill_ready) |=> wbin_r == $past(wbin_r))
    else $error("read taken into a full buffer");
  chk_buffer_bound: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (wbin_r - rg_bin) <= sbi_pkg::PTR_DEPTH)
    else $error("crossing buffer overrun");
  // A gray pointer that moves more than one bit would break the crossing
  chk_wgray_step: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $countones(wgray_r ^ $past(wgray_r)) <= 1)
    else $error("write pointer moved more than one gray step");

  // Mode detection checks
  chk_mode_drop: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (oc_s2_r != oc_s3_r) |-> ##2 !single_mode_r)
    else $error("single mode kept while output clock toggles");
  chk_idle_sat: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    idle_cnt_r <= sbi_pkg::IDLE_CYC)
    else $error("idle counter ran past its limit");

  // Output burst checks
  sequence s_pop;
    drain_valid;
  endsequence
  sequence s_drive_low_half;
    !q_oe_n_r && q_pos_r == $past(fifo_r[rbin_r[0]][sbi_pkg::DATA_W-1:0]);
  endsequence

  chk_burst_data: assert property (@(posedge launch_clk) disable iff (!reset_n_i)
    s_pop |=> s_drive_low_half)
    else $error("first transfer not launched from buffer");
  chk_hiz_after: assert property (@(posedge launch_clk) disable iff (!reset_n_i)
    !drain_valid |=> q_oe_n_r)
    else $error("outputs not floated after deselect");
  chk_burst_hold: assert property (@(posedge launch_clk) disable iff (!reset_n_i)
    s_pop |=> q_hold_r == $past(fifo_r[rbin_r[0]][sbi_pkg::WORD_W-1:sbi_pkg::DATA_W]))
    else $error("second transfer not staged");
  chk_rgray_step: assert property (@(posedge launch_clk) disable iff (!reset_n_i)
    $countones(rgray_r ^ $past(rgray_r)) <= 1)
    else $error("read pointer moved more than one gray step");

endmodule

// ### bench/sbi_ctrl_model.sv
/*
  Memory controller model that drives the burst SRAM pins: shared address,
  port selects, byte selects, write data and the output clock.
  Assumes sys_clk_i is the positive input clock of the device under test.
*/
`timescale 1ns/1ps
module sbi_ctrl_model (
  input wire logic sys_clk_i,
  output logic out_clk_o,
  output logic [20:0] addr_o,
  output logic write_port_select_n_o,
  output logic read_port_select_n_o,
  output logic [3:0] byte_write_select_n_o,
  output logic [35:0] wdata_o
);
  logic run = 1'b1;
  initial
  begin
    out_clk_o = 1'b1;
    addr_o = 21'h0;
    write_port_select_n_o = 1'b1;
    read_port_select_n_o = 1'b1;
    byte_write_select_n_o = 4'hF;
    wdata_o = 36'h0;
  end
  // Output clock toggles freely, or rests high to ask for single mode
  always #3 out_clk_o = run ? ~out_clk_o : 1'b1;
  // One request cycle: read address with selects at the positive edge, write address
  // at the negative edge; released lines show inverted junk, not stale data
  task automatic issue(input logic rd, input logic wr, input logic [20:0] ra,
    input logic [20:0] wa, input logic [35:0] lo, input logic [35:0] hi,
    input logic [3:0] b0, input logic [3:0] b1);
    @(negedge sys_clk_i);
    read_port_select_n_o = ~rd;
    write_port_select_n_o = ~wr;
    addr_o = ra;
    wdata_o = lo;
    byte_write_select_n_o = b0;
    @(posedge sys_clk_i);
    #2;
    addr_o = wa;
    wdata_o = hi;
    byte_write_select_n_o = b1;
    // Second half must stand across the negative edge that samples it
    @(negedge sys_clk_i);
    #2;
    read_port_select_n_o = 1'b1;
    write_port_select_n_o = 1'b1;
    addr_o = ~wa;
    wdata_o = ~hi;
    byte_write_select_n_o = ~b1;
  endtask
  // Two reads on consecutive positive edges fill both buffer entries
  task automatic read_pair(input logic [20:0] a0, input logic [20:0] a1);
    @(negedge sys_clk_i);
    read_port_select_n_o = 1'b0;
    addr_o = a0;
    @(negedge sys_clk_i);
    addr_o = a1;
    @(negedge sys_clk_i);
    read_port_select_n_o = 1'b1;
    addr_o = ~a1;
  endtask
endmodule

// ### bench/test_separate_port_ddr_burst_sram_interface.sv
/*
  Self-checking bench for the burst SRAM pin logic: writes, byte masks,
  deselected ports, reads, echo clocks and single clock mode.
  Assumes the controller model drives every input except clock and reset.
*/
`timescale 1ns/1ps
module test_separate_port_ddr_burst_sram_interface;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic out_clk, wr_sel_n, rd_sel_n, rdata_oe_n_o, echo_clock_pos_o, echo_clock_neg_o;
  logic [20:0] addr;
  logic [3:0] byte_sel_n;
  logic [35:0] wdata, rdata_o, lo_q;
  logic [71:0] got[$];
  int err_total = 0;
  int n_compared = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  sbi_sram_if #(.MEM_AW(6)) i_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .out_clk_i(out_clk), .addr_i(addr), .write_port_select_n_i(wr_sel_n),
    .read_port_select_n_i(rd_sel_n), .byte_write_select_n_i(byte_sel_n), .wdata_i(wdata),
    .rdata_o(rdata_o), .rdata_oe_n_o(rdata_oe_n_o), .echo_clock_pos_o(echo_clock_pos_o),
    .echo_clock_neg_o(echo_clock_neg_o));
  sbi_ctrl_model i_ctl (.sys_clk_i(sys_clk_i), .out_clk_o(out_clk), .addr_o(addr),
    .write_port_select_n_o(wr_sel_n), .read_port_select_n_o(rd_sel_n),
    .byte_write_select_n_o(byte_sel_n), .wdata_o(wdata));
  // Capture bursts 1.5 ns after each echo edge, clear of the launch edges
  always @(posedge echo_clock_pos_o)
  begin
    #1.5;
    if (rdata_oe_n_o === 1'b0) lo_q = rdata_o;
  end
  always @(negedge echo_clock_pos_o)
  begin
    #1.5;
    if (rdata_oe_n_o === 1'b0) got.push_back({rdata_o, lo_q});
  end
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Wait a bounded time for one burst; a missing burst compares as unknown
  task automatic rd_chk(input logic [20:0] a, input logic [71:0] exp);
    i_ctl.issue(1'b1, 1'b0, a, 21'h0, 36'h0, 36'h0, 4'hF, 4'hF);
    repeat (20) if (got.size() == 0) @(posedge sys_clk_i);
    check(got.size() > 0 ? got.pop_front() : 72'hx, exp);
  endtask
  function automatic logic [35:0] mrg(logic [35:0] o, logic [35:0] n, logic [3:0] bn);
    mrg = o;
    for (int i = 0; i < 4; i++) if (!bn[i]) mrg[i*9+:9] = n[i*9+:9];
  endfunction
  task automatic t_basic();
    i_ctl.issue(1'b0, 1'b1, 21'h0, 21'h05, 36'hA_1234_5678, 36'hB_8765_4321, 4'h0, 4'h0);
    // Read of 5 and write of 7 share one cycle on the address bus
    i_ctl.issue(1'b1, 1'b1, 21'h05, 21'h07, 36'h1_1111_1111, 36'h2_2222_2222, 4'h0, 4'h0);
    repeat (20) if (got.size() == 0) @(posedge sys_clk_i);
    check(got.size() > 0 ? got.pop_front() : 72'hx, 72'hB_8765_4321_A_1234_5678);
    rd_chk(21'h07, 72'h2_2222_2222_1_1111_1111);
  endtask
  task automatic t_bytes();
    i_ctl.issue(1'b0, 1'b1, 21'h0, 21'h07, 36'hF_FFFF_FFFF, 36'h0, 4'hA, 4'h5);
    rd_chk(21'h07, {mrg(36'h2_2222_2222, 36'h0, 4'h5),
      mrg(36'h1_1111_1111, 36'hF_FFFF_FFFF, 4'hA)});
  endtask
  task automatic t_desel();
    i_ctl.issue(1'b0, 1'b0, 21'h05, 21'h05, 36'h0, 36'h0, 4'h0, 4'h0);
    repeat (8) @(posedge sys_clk_i);
    check(72'(got.size()), 72'h0);
    rd_chk(21'h05, 72'hB_8765_4321_A_1234_5678);
  endtask
  task automatic t_b2b();
    i_ctl.read_pair(21'h05, 21'h07);
    repeat (20) if (got.size() < 2) @(posedge sys_clk_i);
    check(got.size() > 0 ? got.pop_front() : 72'hx, 72'hB_8765_4321_A_1234_5678);
    check(got.size() > 0 ? got.pop_front() : 72'hx, {mrg(36'h2_2222_2222, 36'h0, 4'h5),
      mrg(36'h1_1111_1111, 36'hF_FFFF_FFFF, 4'hA)});
    repeat (3) @(posedge sys_clk_i);
    check(72'(rdata_oe_n_o), 72'h1);
  endtask
  task automatic t_echo();
    repeat (3)
    begin
      @(posedge out_clk);
      #1;
      check(72'({echo_clock_pos_o, echo_clock_neg_o}), 72'h2);
    end
    i_ctl.run = 1'b0;
    repeat (12) @(posedge sys_clk_i);
    #5;
    check(72'({echo_clock_pos_o, echo_clock_neg_o}), 72'h2);
    @(negedge sys_clk_i);
    #5;
    check(72'({echo_clock_pos_o, echo_clock_neg_o}), 72'h1);
    rd_chk(21'h05, 72'hB_8765_4321_A_1234_5678);
  endtask
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Runs take about 48 sys cycles; the watchdog allows 4000, over seventy times that
  initial
  begin
    #100000;
    err_total++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    t_basic();
    t_bytes();
    t_desel();
    t_b2b();
    t_echo();
    wrap_up();
  end
endmodule
